// File: ptm_ctrl.sv
// periodic timer: registers, counter, compare, capture and output pin
`timescale 1ns/100ps
`default_nettype none
`include "ptm_cfg.svh"
// How it works
// [RQ1] compare mode: on A match hold, drive low, drive high or toggle output
// [RQ2] pwm mode: force inactive, force active, pass pwm, or single pulse
// [RQ3] capture, clear-select 00: rise, fall or both edges into A; 11 disables
// [RQ4] capture, clear-select nonzero: rising edges into B, falling into A
// [RQ5] timer mode ignores pin function, initial level and invert
// [RQ6] compare match requesting the current level shows no change
// [RQ7] counter-on rising restores output to the initial level
// [RQ8] software changes pin function only while the timer is off
// [RQ9] level bit: initial level in compare, active level in pwm
// [RQ10] single pulse takes the active level when counter-on rises
// [RQ11] invert bit inverts the output pin
// [RQ12] capture source: input pin when 0, external clock pin when 1
// [RQ13] clear select 1 clears on A match, 0 on P match or overflow
// [RQ14] overflow clear only when period register is zero
// [RQ15] clear select ignored in pwm, single pulse and capture modes
// [RQ16] capture mode clears on P match plus chosen pin edges
// [RQ17] capture-clear select matters only in capture mode
// [RQ18] latch-edge flag reads 1 for rising capture, 0 for falling
// [RQ19] counter readable as low byte and two-bit high byte
// [RQ20] A, B and P are 10-bit read/write split registers, reset zero
// [RQ21] unimplemented control and high-byte bits read zero
// [RQ22] mode field: compare, capture, pwm/single pulse, timer
// [RQ23] counter-on rising zeroes counter; falling stops and holds it
// [RQ24] pins are synchronised and edges taken from registered samples
module ptm_ctrl (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`PTM_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // count enable from the clock selector
    input wire logic count_tick_i,
    // pins
    input wire logic capture_input_pin_i,
    input wire logic external_clock_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_o,
    // event pulses
    output logic match_a_o,
    output logic match_p_o,
    output logic capture_o
);
    ptm_pkg::ptm_state_t s_reg;
    ptm_pkg::ptm_state_t s_next;

    // ------------
    // pin edges
    // ------------
    pin_edge_if pi_edge ();
    pin_edge_if ck_edge ();

    pin_edge_sync u_pi_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(capture_input_pin_i),
        .edge_o(pi_edge.src)
    ); // RQ24

    pin_edge_sync u_ck_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(external_clock_pin_i),
        .edge_o(ck_edge.src)
    ); // RQ24

    // ------------
    // decode helpers
    // ------------
    ptm_pkg::mode_t mode;
    ptm_pkg::pin_func_t pf;
    ptm_pkg::clr_sel_t ccs;
    logic oc, pol, cclr, wr, mapped;
    logic [9:0] inc;

    assign mode = ptm_pkg::mode_t'(s_reg.ctrl1[`PTM_MODE_HI:`PTM_MODE_LO]); // RQ22
    assign pf = ptm_pkg::pin_func_t'(s_reg.ctrl1[`PTM_PF_HI:`PTM_PF_LO]);
    assign ccs = ptm_pkg::clr_sel_t'(s_reg.ccs);
    assign oc = s_reg.ctrl1[`PTM_OC_BIT];
    assign pol = s_reg.ctrl1[`PTM_POL_BIT];
    assign cclr = s_reg.ctrl1[`PTM_CCLR_BIT];
    assign wr = psel_i & penable_i & pwrite_i;
    assign inc = s_reg.cnt + `PTM_ONE;
    assign mapped = (paddr_i <= `PTM_OFF_P_HI) && (paddr_i[1:0] == 2'h0);

    // ------------
    // next state
    // ------------
    logic on_rise, step, rise, fall, a_hit, p_hit, clr, single, split, cap_rise, cap_fall, edge_clr, pwm_act, lvl;

    always_comb begin
        s_next = s_reg;
        s_next.on_prev = s_reg.on;
        s_next.ev_a = 1'b0;
        s_next.ev_p = 1'b0;
        s_next.ev_cap = 1'b0;
        on_rise = s_reg.on & ~s_reg.on_prev;
        step = s_reg.on & ~s_reg.pause & count_tick_i & ~on_rise;
        // RQ12
        rise = s_reg.ctrl1[`PTM_CAPTS_BIT] ? ck_edge.rise : pi_edge.rise;
        fall = s_reg.ctrl1[`PTM_CAPTS_BIT] ? ck_edge.fall : pi_edge.fall;
        // a zero compare value never matches
        a_hit = step & (s_reg.a != `PTM_RST_WORD) & (inc == s_reg.a);
        // zero period leaves only the natural wrap at 3FF
        p_hit = step & (s_reg.p != `PTM_RST_WORD) & (inc == s_reg.p); // RQ14
        single = (mode == ptm_pkg::MODE_PWM) && (pf == ptm_pkg::PF_TOGGLE);
        split = (ccs != ptm_pkg::CC_P_ONLY);
        cap_rise = 1'b0;
        cap_fall = 1'b0;
        edge_clr = 1'b0;
        clr = 1'b0;

        // ----- software writes -----
        if (wr) begin
            case (paddr_i)
                `PTM_OFF_CTRL0: begin
                    s_next.on = pwdata_i[`PTM_ON_BIT];
                    s_next.pause = pwdata_i[`PTM_PAUSE_BIT];
                end
                `PTM_OFF_CTRL1: begin
                    s_next.ctrl1 = pwdata_i[7:0];
                end
                `PTM_OFF_CTRL2: begin
                    s_next.ccs = pwdata_i[`PTM_CCS_HI:`PTM_CCS_LO];
                end
                `PTM_OFF_A_LO: begin
                    s_next.a[7:0] = pwdata_i[7:0]; // RQ20
                end
                `PTM_OFF_A_HI: begin
                    s_next.a[9:8] = pwdata_i[1:0];
                end
                `PTM_OFF_B_LO: begin
                    s_next.b[7:0] = pwdata_i[7:0];
                end
                `PTM_OFF_B_HI: begin
                    s_next.b[9:8] = pwdata_i[1:0];
                end
                `PTM_OFF_P_LO: begin
                    s_next.p[7:0] = pwdata_i[7:0];
                end
                `PTM_OFF_P_HI: begin
                    s_next.p[9:8] = pwdata_i[1:0];
                end
                default: begin
                end
            endcase
        end

        // ----- counter clear source by mode -----
        case (mode)
            ptm_pkg::MODE_CMP,
            ptm_pkg::MODE_TMR: begin
                clr = cclr ? a_hit : p_hit; // RQ13
                s_next.ev_a = a_hit;
                s_next.ev_p = p_hit & ~cclr;
            end
            ptm_pkg::MODE_PWM: begin
                // clear select ignored here
                clr = single ? 1'b0 : p_hit; // RQ15
                s_next.ev_a = a_hit;
                s_next.ev_p = p_hit & ~single;
                if (single && a_hit) begin
                    // pulse ends: hardware drops counter-on
                    s_next.on = 1'b0;
                end
            end
            ptm_pkg::MODE_CAP: begin
                s_next.ev_a = a_hit;
                s_next.ev_p = p_hit;
                if (s_reg.on) begin
                    cap_rise = rise & ((pf == ptm_pkg::PF_HOLD) | (pf == ptm_pkg::PF_HIGH)); // RQ3
                    cap_fall = fall & ((pf == ptm_pkg::PF_LOW) | (pf == ptm_pkg::PF_HIGH)); // RQ3
                    case (ccs)
                        ptm_pkg::CC_RISE: begin
                            edge_clr = rise; // RQ16
                        end
                        ptm_pkg::CC_FALL: begin
                            edge_clr = fall; // RQ16
                        end
                        ptm_pkg::CC_BOTH: begin
                            edge_clr = rise | fall; // RQ16
                        end
                        default: begin
                        end
                    endcase
                end
                clr = p_hit; // RQ16
            end
            default: begin
                clr = p_hit;
            end
        endcase

        // ----- capture into A or B -----
        if (cap_rise) begin
            if (split) begin
                s_next.b = s_reg.cnt; // RQ4
            end else begin
                s_next.a = s_reg.cnt; // RQ3
            end
            s_next.vlf = 1'b1; // RQ18
        end
        if (cap_fall) begin
            s_next.a = s_reg.cnt; // RQ4
            s_next.vlf = 1'b0; // RQ18
        end
        s_next.ev_cap = cap_rise | cap_fall;

        // ----- counter -----
        if (on_rise) begin
            s_next.cnt = `PTM_RST_WORD; // RQ23
            s_next.out_lvl = oc; // RQ7 RQ10
        end else begin
            if (step) begin
                // off: counter holds; paused: holds except for capture-mode pin-edge clears
                s_next.cnt = clr ? `PTM_RST_WORD : inc; // RQ23
            end
            if (edge_clr) begin
                s_next.cnt = `PTM_RST_WORD; // RQ17
            end
            if (a_hit && mode == ptm_pkg::MODE_CMP) begin
                // requested level equal to current gives no change
                case (pf)
                    ptm_pkg::PF_LOW: begin
                        s_next.out_lvl = 1'b0; // RQ1 RQ6
                    end
                    ptm_pkg::PF_HIGH: begin
                        s_next.out_lvl = 1'b1; // RQ1 RQ6
                    end
                    ptm_pkg::PF_TOGGLE: begin
                        s_next.out_lvl = ~s_reg.out_lvl; // RQ1
                    end
                    default: begin // RQ1
                    end
                endcase
            end
        end

        // ----- output pin -----
        // duty at or above period gives a full-on wave
        pwm_act = (s_reg.cnt < s_reg.a);
        case (pf)
            ptm_pkg::PF_HOLD: begin
                lvl = ~oc; // RQ2
            end
            ptm_pkg::PF_LOW: begin
                lvl = oc; // RQ2
            end
            ptm_pkg::PF_HIGH: begin
                lvl = pwm_act ? oc : ~oc; // RQ2 RQ9
            end
            default: begin
                lvl = s_reg.on ? oc : ~oc; // RQ2 RQ10
            end
        endcase
        case (mode)
            ptm_pkg::MODE_CMP: begin
                s_next.pin = s_reg.out_lvl ^ pol; // RQ9 RQ11
                s_next.pin_oe = 1'b1;
            end
            ptm_pkg::MODE_PWM: begin
                s_next.pin = lvl ^ pol; // RQ11
                s_next.pin_oe = 1'b1;
            end
            default: begin
                // no output function: pin released
                s_next.pin = 1'b0; // RQ5
                s_next.pin_oe = 1'b0; // RQ5
            end
        endcase

        // ----- read data, taken in the setup cycle -----
        if (psel_i && !penable_i) begin
            s_next.rdata = 32'h0000_0000; // RQ21
            case (paddr_i)
                `PTM_OFF_CTRL0: begin
                    s_next.rdata[`PTM_ON_BIT] = s_reg.on;
                    s_next.rdata[`PTM_PAUSE_BIT] = s_reg.pause;
                end
                `PTM_OFF_CTRL1: begin
                    s_next.rdata[7:0] = s_reg.ctrl1;
                end
                `PTM_OFF_CTRL2: begin
                    s_next.rdata[`PTM_CCS_HI:`PTM_CCS_LO] = s_reg.ccs;
                    s_next.rdata[`PTM_VLF_BIT] = s_reg.vlf; // RQ18
                end
                `PTM_OFF_CNT_LO: begin
                    s_next.rdata[7:0] = s_reg.cnt[7:0]; // RQ19
                end
                `PTM_OFF_CNT_HI: begin
                    s_next.rdata[1:0] = s_reg.cnt[9:8]; // RQ19
                end
                `PTM_OFF_A_LO: begin
                    s_next.rdata[7:0] = s_reg.a[7:0];
                end
                `PTM_OFF_A_HI: begin
                    s_next.rdata[1:0] = s_reg.a[9:8];
                end
                `PTM_OFF_B_LO: begin
                    s_next.rdata[7:0] = s_reg.b[7:0];
                end
                `PTM_OFF_B_HI: begin
                    s_next.rdata[1:0] = s_reg.b[9:8];
                end
                `PTM_OFF_P_LO: begin
                    s_next.rdata[7:0] = s_reg.p[7:0];
                end
                `PTM_OFF_P_HI: begin
                    s_next.rdata[1:0] = s_reg.p[9:8];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------
    // state register
    // ------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0; // RQ20
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------
    // outputs
    // ------------
    // zero wait states; a reply is always ready in the access phase
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o = s_reg.rdata;
    assign timer_output_pin_o = s_reg.pin;
    assign timer_output_pin_oe_o = s_reg.pin_oe;
    assign match_a_o = s_reg.ev_a;
    assign match_p_o = s_reg.ev_p;
    assign capture_o = s_reg.ev_cap;
endmodule // ptm_ctrl
`default_nettype wire

// File: ptm_cfg.svh
// register offsets, field positions, reset values of the periodic timer
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
`define PTM_ADDR_W 8
`define PTM_OFF_CTRL0 8'h00
`define PTM_OFF_CTRL1 8'h04
`define PTM_OFF_CTRL2 8'h08
`define PTM_OFF_CNT_LO 8'h0C
`define PTM_OFF_CNT_HI 8'h10
`define PTM_OFF_A_LO 8'h14
`define PTM_OFF_A_HI 8'h18
`define PTM_OFF_B_LO 8'h1C
`define PTM_OFF_B_HI 8'h20
`define PTM_OFF_P_LO 8'h24
`define PTM_OFF_P_HI 8'h28
`define PTM_ON_BIT 3
`define PTM_PAUSE_BIT 7
`define PTM_MODE_HI 7
`define PTM_MODE_LO 6
`define PTM_PF_HI 5
`define PTM_PF_LO 4
`define PTM_OC_BIT 3
`define PTM_POL_BIT 2
`define PTM_CAPTS_BIT 1
`define PTM_CCLR_BIT 0
`define PTM_CCS_HI 2
`define PTM_CCS_LO 1
`define PTM_VLF_BIT 0
`define PTM_RST_WORD 10'h000
`define PTM_ONE 10'h001
`endif

// File: ptm_pkg.sv
// types shared by the periodic timer design
package ptm_pkg;
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } mode_t;
    // names follow compare mode; pwm and capture reuse the same codes
    typedef enum logic [1:0] {
        PF_HOLD = 2'b00,
        PF_LOW = 2'b01,
        PF_HIGH = 2'b10,
        PF_TOGGLE = 2'b11
    } pin_func_t;
    typedef enum logic [1:0] {
        CC_P_ONLY = 2'b00,
        CC_RISE = 2'b01,
        CC_FALL = 2'b10,
        CC_BOTH = 2'b11
    } clr_sel_t;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_state_t;
    typedef struct packed {
        logic on;
        logic on_prev;
        logic pause;
        logic [7:0] ctrl1;
        logic [1:0] ccs;
        logic vlf;
        logic [9:0] cnt;
        logic [9:0] a;
        logic [9:0] b;
        logic [9:0] p;
        logic out_lvl;
        logic pin;
        logic pin_oe;
        logic ev_a;
        logic ev_p;
        logic ev_cap;
        logic [31:0] rdata;
    } ptm_state_t;
endpackage

// File: pin_edge_if.sv
// edge pulses from a synchronised pin
`timescale 1ns/100ps
`default_nettype none
interface pin_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface
`default_nettype wire

// File: pin_edge_sync.sv
// two-flop pin synchroniser with registered edge detect
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // pin and edges
    input wire logic pin_i,
    pin_edge_if.src edge_o
);
    ptm_pkg::sync_state_t s_reg;
    ptm_pkg::sync_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.s1 = pin_i;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // s1 feeds only s2; edges come from s2/s3
    assign edge_o.rise = s_reg.s2 & ~s_reg.s3;
    assign edge_o.fall = ~s_reg.s2 & s_reg.s3;
endmodule // pin_edge_sync
`default_nettype wire

// File: ptm_pin_model.sv
// pin-side model: drives the capture and external clock pins
`timescale 1ns/100ps
`default_nettype none
module ptm_pin_model (
    // clock
    input wire logic core_clk_i,
    // bench control
    input wire logic sel_i,
    input wire logic lvl_i,
    // pins
    output logic capture_input_pin_o = 1'b0,
    output logic external_clock_pin_o = 1'b0
);
    logic [15:0] noise = 16'hACE1;
    // unselected pin wanders, so a wrong source choice shows up
    always @(posedge core_clk_i) begin
        noise <= {noise[14:0], noise[15] ^ noise[13] ^ noise[12] ^ noise[10]};
        capture_input_pin_o <= sel_i ? noise[0] : lvl_i;
        external_clock_pin_o <= sel_i ? lvl_i : noise[0];
    end
endmodule // ptm_pin_model
`default_nettype wire

// File: ptm_ctrl_monitor.sv
// concurrent checks on the periodic timer ports
`timescale 1ns/100ps
`default_nettype none
`include "ptm_cfg.svh"
module ptm_ctrl_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`PTM_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // counter and pins
    input wire logic count_tick_i,
    input wire logic capture_input_pin_i,
    input wire logic external_clock_pin_i,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_oe_o,
    // events
    input wire logic match_a_o,
    input wire logic match_p_o,
    input wire logic capture_o
);
    // ------------
    // helper state
    // ------------
    logic [7:0] ctl_sh, cap_hist, ck_hist;
    logic [1:0] stab;
    logic acc, settled;
    assign acc = psel_i && penable_i;
    // outputs lag a control write by two edges
    assign settled = stab[1];
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_sh <= 8'h00;
            stab <= 2'h0;
            cap_hist <= 8'h00;
            ck_hist <= 8'h00;
        end else begin
            cap_hist <= {cap_hist[6:0], capture_input_pin_i};
            ck_hist <= {ck_hist[6:0], external_clock_pin_i};
            if (acc && pwrite_i && paddr_i == `PTM_OFF_CTRL1) begin
                ctl_sh <= pwdata_i[7:0];
                stab <= 2'h0;
            end else if (!stab[1]) begin
                stab <= stab + 2'h1;
            end
        end
    end
    // ----------
    // assertions
    // ----------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_ready_always: assert property (acc |-> pready_o)
        else $error("pready low in access");
    a_error_unmapped: assert property (acc |-> pslverr_o == (paddr_i > `PTM_OFF_P_HI || paddr_i[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_high_unused_zero: assert property (acc && !pwrite_i && paddr_i inside {8'h10, 8'h18, 8'h20, 8'h28}
        |-> prdata_o[31:2] == 30'h0)
        else $error("high register unused bits set");
    a_ctrl_unused_zero: assert property (acc && !pwrite_i && paddr_i == 8'h08 |-> prdata_o[31:3] == 29'h0)
        else $error("control 2 unused bits set");
    a_read_data_hold: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o))
        else $error("read data moved outside setup");
    a_release_pin: assert property (settled && ctl_sh[6] |-> !timer_output_pin_oe_o && !timer_output_pin_o)
        else $error("pin driven in timer or capture mode");
    a_drive_pin: assert property (settled && !ctl_sh[6] |-> timer_output_pin_oe_o)
        else $error("pin not driven in output mode");
    a_no_p_match: assert property (settled && ctl_sh[7] == ctl_sh[6] && ctl_sh[0] |-> !match_p_o)
        else $error("p match with clear on a");
    a_capture_cause: assert property (capture_o |-> (cap_hist != 8'h00 && cap_hist != 8'hFF)
        || (ck_hist != 8'h00 && ck_hist != 8'hFF))
        else $error("capture without pin edge");
    a_cmp_pin_level: assert property (settled && ctl_sh[7:6] == 2'b00 && ctl_sh[5] != ctl_sh[4] && match_a_o
        |-> ##[1:3] timer_output_pin_o == (ctl_sh[5] ^ ctl_sh[2]))
        else $error("compare match level wrong");
endmodule // ptm_ctrl_monitor
bind ptm_ctrl ptm_ctrl_monitor mon (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .count_tick_i(count_tick_i),
    .capture_input_pin_i(capture_input_pin_i), .external_clock_pin_i(external_clock_pin_i),
    .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe_o(timer_output_pin_oe_o),
    .match_a_o(match_a_o), .match_p_o(match_p_o), .capture_o(capture_o));
`default_nettype wire

// File: ptm_ctrl_tb.sv
// self-checking bench of the periodic timer block
`timescale 1ns/100ps
`default_nettype none
module ptm_ctrl_tb;
    // -------------
    // bench signals
    // -------------
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0, sel = 1'b0, lvl = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h01AA0792;
    logic pready, pslverr, err, cap_pin, ck_pin, out_pin, out_oe, oc, pol, vlf;
    logic [1:0] pf, ccs;
    logic [9:0] ea, eb;
    int n_mismatch = 0, num_checks = 0, cyc = 0, k1;
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    ptm_ctrl uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .count_tick_i(tick), .capture_input_pin_i(cap_pin),
        .external_clock_pin_i(ck_pin), .timer_output_pin_o(out_pin), .timer_output_pin_oe_o(out_oe),
        .match_a_o(), .match_p_o(), .capture_o());
    ptm_pin_model pins (.core_clk_i(core_clk_i), .sel_i(sel), .lvl_i(lvl),
        .capture_input_pin_o(cap_pin), .external_clock_pin_o(ck_pin));
    // -------------
    // tasks
    // -------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
        return seed;
    endfunction
    function automatic logic cmp_lvl(input logic [1:0] f, input logic o);
        return (f == 2'b00) ? o : (f == 2'b11) ? !o : f[1];
    endfunction
    // 0 no capture, 1 into A, 2 into B
    function automatic logic [1:0] cap_to(input logic [1:0] f, input logic [1:0] s, input logic rise);
        if (f == 2'b11 || (f == 2'b00 && !rise) || (f == 2'b01 && rise)) return 2'd0;
        return (s != 2'b00 && rise) ? 2'd2 : 2'd1;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // an idle edge ends every transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(what, exp, rd);
    endtask
    task automatic w10(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge core_clk_i);
            tick <= 1'b0;
            @(posedge core_clk_i);
        end
    endtask
    task automatic cap_step(input logic rise, input logic [9:0] v);
        logic [1:0] t;
        t = cap_to(pf, ccs, rise);
        lvl <= rise;
        idle(8);
        if (t == 2'd1) ea = v;
        if (t == 2'd2) eb = v;
        if (t != 2'd0) vlf = rise;
        rchk("capture a", 8'h14, 32'(ea[7:0]));
        rchk("capture b", 8'h1C, 32'(eb[7:0]));
        rchk("edge flag", 8'h08, 32'({ccs, vlf}));
        rchk("edge clear", 8'h0C, ((ccs[0] && rise) || (ccs[1] && !rise)) ? 32'h0 : 32'(v[7:0]));
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    // -------------
    // main sequence
    // -------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        @(posedge core_clk_i);
        for (int i = 0; i < 11; i++) rchk("reset value", 8'(4 * i), 32'h0);
        apb(1'b0, 8'h2C, 8'h00);
        chk("unmapped error", 32'h1, 32'(err));
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            w10(8'h14 + 8'(8 * i), r[15:0]);
            rchk("low byte", 8'h14 + 8'(8 * i), 32'(r[7:0]));
            rchk("high bits", 8'h18 + 8'(8 * i), 32'(r[9:8]));
        end
        wr(8'h08, 8'hFF);
        rchk("control 2", 8'h08, 32'h6);
        wr(8'h08, 8'h00);
        $display("test registers done");
        w10(8'h14, 16'h0003);
        w10(8'h24, 16'h0002);
        for (int k = 0; k < 16; k++) begin
            {pol, oc, pf} = 4'(k);
            wr(8'h04, {2'b00, pf, oc, pol, 2'b01});
            wr(8'h00, 8'h08);
            idle(3);
            chk("initial level", 32'(oc ^ pol), 32'(out_pin));
            ticks(3);
            idle(3);
            chk("match level", 32'(cmp_lvl(pf, oc) ^ pol), 32'(out_pin));
            rchk("clear on a", 8'h0C, 32'h0);
            wr(8'h00, 8'h00);
        end
        $display("test compare done");
        w10(8'h14, 16'h0004);
        w10(8'h24, 16'h0008);
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr(8'h04, {2'b10, 2'(k), r[0], r[1], 1'b0, r[2]});
            wr(8'h00, 8'h08);
            idle(3);
            chk("pwm start", 32'(r[0] ^ r[1] ^ (k == 0)), 32'(out_pin));
            ticks(5);
            idle(3);
            chk("pwm later", 32'(r[0] ^ r[1] ^ (k != 1)), 32'(out_pin));
            rchk("pulse stop", 8'h00, (k == 3) ? 32'h0 : 32'h8);
            wr(8'h00, 8'h00);
        end
        $display("test pwm done");
        w10(8'h24, 16'h0000);
        vlf = 1'b0;
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            {ccs, pf} = 4'(k);
            sel <= r[0];
            lvl <= 1'b0;
            {ea, eb} = 20'h00000;
            w10(8'h14, 16'h0000);
            w10(8'h1C, 16'h0000);
            wr(8'h08, {5'h00, ccs, 1'b0});
            wr(8'h04, {2'b01, pf, 2'b00, r[0], 1'b0});
            wr(8'h00, 8'h08);
            idle(4);
            k1 = 1 + int'(r[3:1]);
            ticks(k1);
            cap_step(1'b1, 10'(k1));
            ticks(3);
            cap_step(1'b0, (ccs[0] ? 10'h000 : 10'(k1)) + 10'h003);
            wr(8'h00, 8'h00);
        end
        $display("test capture done");
        wr(8'h04, 8'h00);
        w10(8'h14, 16'h0000);
        w10(8'h24, 16'h0005);
        wr(8'h00, 8'h08);
        ticks(5);
        rchk("clear on p", 8'h0C, 32'h0);
        ticks(4);
        wr(8'h00, 8'h00);
        ticks(2);
        rchk("held count", 8'h0C, 32'h4);
        w10(8'h24, 16'h0000);
        wr(8'h00, 8'h08);
        rchk("on zeroes", 8'h0C, 32'h0);
        ticks(1023);
        rchk("count low", 8'h0C, 32'hFF);
        rchk("count high", 8'h10, 32'h3);
        ticks(1);
        rchk("overflow clear", 8'h0C, 32'h0);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'hFF);
        idle(3);
        chk("timer mode pin", 32'h0, 32'({out_oe, out_pin}));
        $display("test counter done");
        summarize();
    end
endmodule // ptm_ctrl_tb
`default_nettype wire
